/* smc_top.sv */
// System bus memory controller: arbiter, decoder, alignment and protection checks, abort status.
// What this block does
// - Only little-endian byte ordering is served, for both masters.
// - Fixed priority: the DMA master always wins over the processor.
// - Top address nibble splits space into 256 MB regions; undefined ones abort.
// - Eight more address bits pick a 1 MB slot within internal memory.
// - Memories smaller than their slot repeat across the whole slot.
// - An unallocated internal-memory slot aborts the access.
// - Slot zero shows flash before remap and SRAM after; both stay at home.
// - Writing one to the remap bit toggles remap; zero does nothing.
// - Abort causes are undefined address, protection violation and misalignment only.
// - The abort line goes to every master whichever one made the access.
// - Each abort captures the full 32-bit access address, overwriting the old.
// - Each abort records size, type and the cause in the status register.
// - Status shows last aborting master and per-master sticky flags cleared by read.
// - For data aborts the captured address is the data address itself.
// - Sixteen protection areas; unit off after reset until the enable bit is set.
// - Area sizes 1 KB to 4 MB; only base bits above the size match.
// - A separate peripheral permission guards the peripheral region the same way.
// - With protection on, a forbidden write or user access aborts and is recorded.
// - Overlapping areas: the most restrictive permission governs.
// - With protection on, internal accesses matching no area abort.
// - Misaligned word or half-word accesses abort and are cancelled.
// - Processor instruction fetches skip the alignment check.
//
// Implementation choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ns
module smc_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic aclk_en,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic dma_req,
  input wire logic [31:0] dma_addr,
  input wire logic [1:0] dma_size,
  input wire logic dma_write,
  output logic dma_grant,
  input wire logic cpu_req,
  input wire logic [31:0] cpu_addr,
  input wire logic [1:0] cpu_size,
  input wire logic cpu_write,
  input wire logic cpu_fetch,
  input wire logic cpu_priv,
  output logic cpu_grant,
  output logic mem_valid,
  output smc_pkg::smc_sel_t mem_sel,
  output logic [31:0] mem_addr,
  output logic mem_by_cpu,
  output logic bus_abort,
  output logic remap_active
);
  import smc_pkg::*;

  // ----------------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic remap;
    logic pu_en;
    logic [NUM_AREAS-1:0][31:0] area;
    logic [1:0] periph_perm;
    logic [31:0] asr;
    logic [31:0] aasr;
    logic aw_done;
    logic w_done;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic acc_valid;
    smc_sel_t acc_sel;
    logic [31:0] acc_addr;
    logic abort;
    logic acc_cpu;
  } smc_state_t;

  smc_state_t r;
  smc_state_t next_r;

  // ----------------------------------------------------------------------------
  // Arbitration and request selection
  // ----------------------------------------------------------------------------
  logic a_valid;
  logic a_dma;
  logic [31:0] a_addr;
  logic [1:0] a_size;
  logic a_write;
  logic a_fetch;
  logic a_priv;

  // Hard-wired priority; no fairness, so a DMA master that never lets go starves the core.
  assign dma_grant = aclk_en & dma_req;
  assign cpu_grant = aclk_en & cpu_req & ~dma_req;
  assign a_valid = dma_req | cpu_req;
  assign a_dma = dma_req;
  assign a_addr = a_dma ? dma_addr : cpu_addr;
  assign a_size = a_dma ? dma_size : cpu_size;
  assign a_write = a_dma ? dma_write : cpu_write;
  assign a_fetch = ~a_dma & cpu_fetch;
  assign a_priv = a_dma ? DMA_PRIVILEGED : cpu_priv;

  // ----------------------------------------------------------------------------
  // Address decoding
  // ----------------------------------------------------------------------------
  logic [3:0] region;
  logic [7:0] slot;
  logic in_mem;
  logic in_periph;
  logic undef_addr;
  logic misaligned;

  // The region nibble picks memory, peripherals or a hole; inside memory the slot picks a device.
  assign region = a_addr[REGION_MSB:REGION_LSB];
  assign slot = a_addr[SLOT_MSB:SLOT_LSB];
  assign in_mem = (region == REGION_MEMORY);
  assign in_periph = (region == REGION_PERIPH);
  assign undef_addr = ~(in_mem | in_periph) |
                      (in_mem & ~(slot == SLOT_ZERO || slot == SLOT_FLASH || slot == SLOT_SRAM));

  // Fetches are exempt because the core realigns its own fetch address.
  assign misaligned = ~a_fetch & (((a_size == SIZE_WORD) & (a_addr[1:0] != 2'h0)) |
                                  ((a_size == SIZE_HALF) & a_addr[0]));

  // ----------------------------------------------------------------------------
  // Protection areas
  // ----------------------------------------------------------------------------
  logic [NUM_AREAS-1:0] area_hit;
  logic [NUM_AREAS-1:0] area_deny;
  logic access_permission_viol;

  // Areas live in the low 4 MB of each region; the region nibble is not compared, only bits 27:22 must be zero.
  for (genvar gi = 0; gi < NUM_AREAS; gi++) begin : g_area
    logic [AREA_BA_W-1:0] mask;
    assign mask = smc_area_mask(r.area[gi][AREA_SIZE_MSB:AREA_SIZE_LSB]);
    assign area_hit[gi] = (a_addr[SLOT_MSB:AREA_TOP_LSB] == '0) &&
                          (((a_addr[AREA_BA_MSB:AREA_BA_LSB] ^ r.area[gi][AREA_BA_MSB:AREA_BA_LSB]) & mask) == '0);
    assign area_deny[gi] = area_hit[gi] &
                           ~smc_perm_ok(r.area[gi][AREA_PERM_MSB:AREA_PERM_LSB], a_priv, a_write);
  end

  // Any denying hit wins over granting ones, and a miss counts as a denial.
  assign access_permission_viol = r.pu_en &
                     ((in_mem & ((|area_deny) | ~(|area_hit))) |
                      (in_periph & ~smc_perm_ok(r.periph_perm, a_priv, a_write)));

  logic abort_now;
  assign abort_now = a_valid & (undef_addr | misaligned | access_permission_viol);

  // ----------------------------------------------------------------------------
  // Register bus handshakes
  // ----------------------------------------------------------------------------
  logic ar_take;
  logic w_commit;
  logic asr_read;
  logic [3:0] ar_idx;
  logic [3:0] aw_idx;
  logic ar_area;
  logic aw_area;

  assign s_axi_awready = aclk_en & ~r.aw_done & ~r.bvalid;
  assign s_axi_wready = aclk_en & ~r.w_done & ~r.bvalid;
  assign s_axi_arready = aclk_en & ~r.rvalid;
  assign ar_take = s_axi_arvalid & s_axi_arready;
  assign w_commit = r.aw_done & r.w_done;
  assign asr_read = ar_take & (s_axi_araddr == OFF_ABORT_STATUS_REG);
  assign ar_idx = 4'((s_axi_araddr - OFF_PROTECTION_AREA_REG) >> 2);
  assign aw_idx = 4'((r.awaddr - OFF_PROTECTION_AREA_REG) >> 2);
  assign ar_area = (s_axi_araddr >= OFF_PROTECTION_AREA_REG) && (s_axi_araddr < OFF_PERIPHERAL_PROTECTION_REG);
  assign aw_area = (r.awaddr >= OFF_PROTECTION_AREA_REG) && (r.awaddr < OFF_PERIPHERAL_PROTECTION_REG);

  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------
  // One process computes the whole next state; register, status and access paths share it.
  always_comb begin
    logic [31:0] merged;
    logic sticky_dma;
    logic sticky_cpu;
    merged = smc_merge(32'h0000_0000, r.wdata, r.wstrb);
    sticky_dma = 1'b0;
    sticky_cpu = 1'b0;
    next_r = r;

    // Write address and data are caught independently, in either order.
    if (s_axi_awvalid && s_axi_awready) begin
      next_r.aw_done = 1'b1;
      next_r.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_r.w_done = 1'b1;
      next_r.wdata = s_axi_wdata;
      next_r.wstrb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_r.bvalid = 1'b0;
    end

    // Commit once both halves are held; status registers ignore writes but still answer OKAY.
    if (w_commit) begin
      next_r.aw_done = 1'b0;
      next_r.w_done = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = RESP_OKAY;
      if (aw_area && r.awaddr[1:0] == 2'h0) begin
        next_r.area[aw_idx] = smc_merge(r.area[aw_idx], r.wdata, r.wstrb) & AREA_WRITE_MASK;
      end else begin
        case (r.awaddr)
          OFF_REMAP_CONTROL_REG: next_r.remap = r.remap ^ merged[REMAP_TOGGLE_BIT];
          OFF_ABORT_STATUS_REG, OFF_ABORT_ADDRESS_REG: next_r.bresp = RESP_OKAY;
          OFF_PERIPHERAL_PROTECTION_REG: begin
            next_r.periph_perm = 2'(smc_merge({30'h0, r.periph_perm}, r.wdata, r.wstrb) & PERM_WRITE_MASK);
          end
          OFF_PROTECTION_ENABLE_REG: begin
            if (r.wstrb[0]) begin
              next_r.pu_en = r.wdata[PROTECTION_ENABLE_BIT];
            end
          end
          default: next_r.bresp = RESP_SLVERR;
        endcase
      end
    end

    // Reads answer one cycle after the address is taken; unmapped words give SLVERR and zero.
    if (s_axi_rvalid && s_axi_rready) begin
      next_r.rvalid = 1'b0;
    end
    if (ar_take) begin
      next_r.rvalid = 1'b1;
      next_r.rresp = RESP_OKAY;
      next_r.rdata = 32'h0000_0000;
      if (ar_area && s_axi_araddr[1:0] == 2'h0) begin
        next_r.rdata = r.area[ar_idx];
      end else begin
        case (s_axi_araddr)
          OFF_REMAP_CONTROL_REG: next_r.rdata = 32'h0000_0000;
          OFF_ABORT_STATUS_REG: next_r.rdata = r.asr;
          OFF_ABORT_ADDRESS_REG: next_r.rdata = r.aasr;
          OFF_PERIPHERAL_PROTECTION_REG: next_r.rdata = {30'h0, r.periph_perm};
          OFF_PROTECTION_ENABLE_REG: next_r.rdata = {31'h0, r.pu_en};
          default: next_r.rresp = RESP_SLVERR;
        endcase
      end
    end

    // Sticky flags: a status read clears them, but an abort in that same cycle still sets them.
    sticky_dma = (r.asr[ASR_STICKY_DMA_ABORT] & ~asr_read) | (abort_now & a_dma);
    sticky_cpu = (r.asr[ASR_STICKY_CPU_ABORT] & ~asr_read) | (abort_now & ~a_dma);
    next_r.asr[ASR_STICKY_DMA_ABORT] = sticky_dma;
    next_r.asr[ASR_STICKY_CPU_ABORT] = sticky_cpu;

    // Every cause that applies is flagged together; the address is kept once.
    if (abort_now) begin
      next_r.aasr = a_addr;
      next_r.asr[ASR_UNDEFINED_ADDRESS_CAUSE] = undef_addr;
      next_r.asr[ASR_MISALIGNED_CAUSE] = misaligned;
      next_r.asr[ASR_PROTECTION_VIOLATION_CAUSE] = access_permission_viol;
      next_r.asr[ASR_ABORT_SIZE_FIELD +: 2] = a_size;
      next_r.asr[ASR_ABORT_TYPE_FIELD +: 2] = a_fetch ? TYPE_FETCH : (a_write ? TYPE_WRITE : TYPE_READ);
      next_r.asr[ASR_LAST_ABORT_BY_DMA] = a_dma;
      next_r.asr[ASR_LAST_ABORT_BY_CPU] = ~a_dma;
    end

    // Access issue: aborted accesses are cancelled; small memories alias across their slot.
    next_r.acc_valid = a_valid & ~abort_now;
    next_r.abort = abort_now;
    next_r.acc_cpu = a_valid & ~a_dma;
    next_r.acc_sel = SEL_NONE;
    next_r.acc_addr = 32'h0000_0000;
    if (a_valid && !abort_now) begin
      if (in_periph) begin
        next_r.acc_sel = SEL_PERIPH;
        next_r.acc_addr = a_addr;
      end else if (slot == SLOT_SRAM || (slot == SLOT_ZERO && r.remap)) begin
        next_r.acc_sel = SEL_SRAM;
        next_r.acc_addr = {{(32-SRAM_AW){1'b0}}, a_addr[SRAM_AW-1:0]};
      end else begin
        next_r.acc_sel = SEL_FLASH;
        next_r.acc_addr = {{(32-FLASH_AW){1'b0}}, a_addr[FLASH_AW-1:0]};
      end
    end
  end

  // Synchronous reset leaves remap cancelled and protection off; the enable freezes everything.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
    end else if (aclk_en) begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------------
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  assign mem_valid = r.acc_valid;
  assign mem_sel = r.acc_sel;
  assign mem_addr = r.acc_addr;
  assign mem_by_cpu = r.acc_cpu;
  assign bus_abort = r.abort;
  assign remap_active = r.remap;

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  a_dma_priority: assert property (@(posedge aclk) disable iff (!aresetn)
    (aclk_en && dma_req && cpu_req) |-> (dma_grant && !cpu_grant))
    else $error("Processor granted while the DMA master requests.");

  a_undef_region: assert property (@(posedge aclk) disable iff (!aresetn)
    (aclk_en && a_valid && region != REGION_MEMORY && region != REGION_PERIPH) |=>
    (bus_abort && r.asr[ASR_UNDEFINED_ADDRESS_CAUSE] && !mem_valid))
    else $error("Undefined region access not aborted.");

  a_misalign_word: assert property (@(posedge aclk) disable iff (!aresetn)
    (aclk_en && a_valid && !a_fetch && a_size == SIZE_WORD && a_addr[1:0] != 2'h0) |=>
    (bus_abort && r.asr[ASR_MISALIGNED_CAUSE]))
    else $error("Misaligned word access not aborted.");

  a_fetch_unchecked: assert property (@(posedge aclk) disable iff (!aresetn)
    (aclk_en && a_valid && a_fetch) |=> !(bus_abort && r.asr[ASR_MISALIGNED_CAUSE]))
    else $error("Instruction fetch flagged as misaligned.");

  a_abort_addr: assert property (@(posedge aclk) disable iff (!aresetn)
    (aclk_en && abort_now) |=> (r.aasr == $past(a_addr)))
    else $error("Abort address not captured.");

  a_remap_toggle: assert property (@(posedge aclk) disable iff (!aresetn)
    (aclk_en && w_commit && r.awaddr == OFF_REMAP_CONTROL_REG && r.wstrb[0] && r.wdata[REMAP_TOGGLE_BIT]) |=>
    (remap_active != $past(remap_active)))
    else $error("Remap did not toggle.");

  a_protect_off: assert property (@(posedge aclk) disable iff (!aresetn)
    (aclk_en && a_valid && !r.pu_en) |=> !(bus_abort && r.asr[ASR_PROTECTION_VIOLATION_CAUSE]))
    else $error("Protection abort while the unit is off.");

  a_sticky_cpu: assert property (@(posedge aclk) disable iff (!aresetn)
    (aclk_en && abort_now && !dma_req) |=>
    (r.asr[ASR_STICKY_CPU_ABORT] && r.asr[ASR_LAST_ABORT_BY_CPU] && !r.asr[ASR_LAST_ABORT_BY_DMA]))
    else $error("Processor abort not recorded.");

  a_alias_sram: assert property (@(posedge aclk) disable iff (!aresetn)
    (aclk_en && a_valid && !abort_now && r.remap && in_mem && slot == SLOT_ZERO) |=>
    (mem_sel == SEL_SRAM && mem_addr[SRAM_AW-1:0] == $past(a_addr[SRAM_AW-1:0])))
    else $error("Remapped slot zero did not reach SRAM.");

  a_area_miss: assert property (@(posedge aclk) disable iff (!aresetn)
    (aclk_en && a_valid && r.pu_en && in_mem && !(|area_hit)) |=>
    (bus_abort && r.asr[ASR_PROTECTION_VIOLATION_CAUSE]))
    else $error("Access outside every area not aborted.");

endmodule : smc_top

/* smc_pkg.sv */
// Constants, types and helper functions of the system bus memory controller.
package smc_pkg;

  // ----------------------------------------------------------------------------
  // Register map (byte offsets on the register bus)
  // ----------------------------------------------------------------------------
  localparam logic [7:0] OFF_REMAP_CONTROL_REG = 8'h00;
  localparam logic [7:0] OFF_ABORT_STATUS_REG = 8'h04;
  localparam logic [7:0] OFF_ABORT_ADDRESS_REG = 8'h08;
  localparam logic [7:0] OFF_PROTECTION_AREA_REG = 8'h10;
  localparam logic [7:0] OFF_PERIPHERAL_PROTECTION_REG = 8'h50;
  localparam logic [7:0] OFF_PROTECTION_ENABLE_REG = 8'h54;
  localparam int NUM_AREAS = 16;

  // ----------------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------------
  localparam int REMAP_TOGGLE_BIT = 0;
  localparam int PROTECTION_ENABLE_BIT = 0;
  localparam int ASR_UNDEFINED_ADDRESS_CAUSE = 0;
  localparam int ASR_MISALIGNED_CAUSE = 1;
  localparam int ASR_PROTECTION_VIOLATION_CAUSE = 2;
  localparam int ASR_ABORT_SIZE_FIELD = 8;
  localparam int ASR_ABORT_TYPE_FIELD = 10;
  localparam int ASR_LAST_ABORT_BY_DMA = 16;
  localparam int ASR_LAST_ABORT_BY_CPU = 17;
  localparam int ASR_STICKY_DMA_ABORT = 24;
  localparam int ASR_STICKY_CPU_ABORT = 25;
  localparam int AREA_PERM_LSB = 0;
  localparam int AREA_PERM_MSB = 1;
  localparam int AREA_SIZE_LSB = 4;
  localparam int AREA_SIZE_MSB = 7;
  localparam int AREA_BA_LSB = 10;
  localparam int AREA_BA_MSB = 21;
  localparam int AREA_BA_W = 12;
  localparam int AREA_TOP_LSB = 22;
  localparam logic [3:0] AREA_SIZE_CODE_MAX = 4'hb;
  localparam logic [31:0] AREA_WRITE_MASK = 32'h003f_fcf3;
  localparam logic [31:0] PERM_WRITE_MASK = 32'h0000_0003;

  // ----------------------------------------------------------------------------
  // Address decoding
  // ----------------------------------------------------------------------------
  localparam int REGION_MSB = 31;
  localparam int REGION_LSB = 28;
  localparam int SLOT_MSB = 27;
  localparam int SLOT_LSB = 20;
  localparam logic [3:0] REGION_MEMORY = 4'h0;
  localparam logic [3:0] REGION_PERIPH = 4'hf;
  localparam logic [7:0] SLOT_ZERO = 8'h00;
  localparam logic [7:0] SLOT_FLASH = 8'h01;
  localparam logic [7:0] SLOT_SRAM = 8'h02;
  localparam int FLASH_AW = 18;
  localparam int SRAM_AW = 15;
  localparam logic DMA_PRIVILEGED = 1'b1;

  // ----------------------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------------------
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [1:0] TYPE_READ = 2'h0;
  localparam logic [1:0] TYPE_WRITE = 2'h1;
  localparam logic [1:0] TYPE_FETCH = 2'h2;
  localparam logic [1:0] PERM_NONE = 2'h0;
  localparam logic [1:0] PERM_PRIV_RW = 2'h1;
  localparam logic [1:0] PERM_USER_RO = 2'h2;
  localparam logic [1:0] PERM_ALL_RW = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {SEL_NONE, SEL_FLASH, SEL_SRAM, SEL_PERIPH} smc_sel_t;

  // ----------------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------------
  // True when a permission code lets this access through.
  function automatic logic smc_perm_ok(input logic [1:0] perm, input logic priv, input logic wr);
    case (perm)
      PERM_PRIV_RW: return priv;
      PERM_USER_RO: return priv | ~wr;
      PERM_ALL_RW: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : smc_perm_ok

  // Marks which base-address bits take part in the compare for a size code.
  function automatic logic [AREA_BA_W-1:0] smc_area_mask(input logic [3:0] size);
    int lsb;
    logic [AREA_BA_W-1:0] m;
    lsb = (size > AREA_SIZE_CODE_MAX) ? AREA_TOP_LSB : AREA_BA_LSB + int'(size);
    for (int j = 0; j < AREA_BA_W; j++) begin
      m[j] = (AREA_BA_LSB + j) >= lsb;
    end
    return m;
  endfunction : smc_area_mask

  // Byte-lane merge, lane 0 holding the least significant byte.
  function automatic logic [31:0] smc_merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        m[8*b +: 8] = d[8*b +: 8];
      end
    end
    return m;
  endfunction : smc_merge

endpackage : smc_pkg

/* smc_mst_model.sv */
// Behavioural model of the two system bus masters.
`timescale 1ns/1ns
module smc_mst_model (
  input wire logic aclk,
  output logic dma_req,
  output logic cpu_req,
  output logic [31:0] addr,
  output logic [1:0] size,
  output logic wr,
  output logic fetch,
  output logic priv
);
  // Both masters share one set of fields and each asks for exactly one edge.
  task automatic issue(input logic d, c, input logic [31:0] a, input logic [1:0] s, input logic w, f, p);
    @(posedge aclk);
    dma_req <= d;
    cpu_req <= c;
    addr <= a;
    size <= s;
    wr <= w;
    fetch <= f;
    priv <= p;
    @(posedge aclk);
    dma_req <= 1'b0;
    cpu_req <= 1'b0;
    addr <= ~a; // A released bus does not keep its last address.
  endtask : issue
  // The bus is idle at time zero.
  initial begin
    {dma_req, cpu_req, wr, fetch, priv} = 5'h0;
    addr = 32'h0;
    size = 2'h0;
  end
endmodule : smc_mst_model

/* testbench.sv */
// Self-checking testbench of the system bus memory controller.
`timescale 1ns/1ns
module testbench;
  import smc_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, dma_req, cpu_req, wr, fetch, priv;
  logic dma_grant, cpu_grant, mem_valid, mem_by_cpu, bus_abort, remap_active, gd, gc, rmp, pen;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, addr, mem_addr, rd, rv;
  logic [1:0] s_axi_bresp, s_axi_rresp, size, rr;
  logic [3:0] s_axi_wstrb;
  smc_sel_t mem_sel;
  int err_count, cmp_count, pp;
  int cyc = 0;
  int ap[16] = '{default: 0};
  int al[16] = '{default: 1024};
  smc_top dut (.aclk, .aresetn, .aclk_en(1'b1), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .dma_req,
    .dma_addr(addr), .dma_size(size), .dma_write(wr), .dma_grant, .cpu_req, .cpu_addr(addr), .cpu_size(size),
    .cpu_write(wr), .cpu_fetch(fetch), .cpu_priv(priv), .cpu_grant, .mem_valid, .mem_sel, .mem_addr,
    .mem_by_cpu, .bus_abort, .remap_active);
  smc_mst_model m (.aclk, .dma_req, .cpu_req, .addr, .size, .wr, .fetch, .priv);
  // Clock of 20 ns.
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // Grants are caught mid-cycle, where the combinational answer has settled.
  always @(negedge aclk) begin
    if (dma_req | cpu_req) begin
      gd <= dma_grant;
      gc <= cpu_grant;
    end
  end
  // A hang ends the run.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      summarize();
    end
  end
  task automatic chk(input logic [31:0] g, e);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  // Register write: address and data offered together, each released when taken.
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    chk(s_axi_bresp, RESP_OKAY);
    s_axi_bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axr
  // One access, flags {dma, cpu, write, fetch, privileged}, judged against the reference model.
  task automatic acc(input logic [4:0] fl, input logic [31:0] a, input logic [1:0] s);
    logic und, mis, pr, cf;
    logic [1:0] t;
    logic [31:0] ea;
    smc_sel_t sel;
    int pm;
    cf = !fl[4] && fl[1];
    und = 1'b0;
    sel = SEL_PERIPH;
    ea = a;
    pm = pp;
    if (a[31:28] != REGION_PERIPH) begin
      pm = 4;
      for (int i = 0; i < NUM_AREAS; i++) begin
        if (a[27:0] < al[i] && ap[i] < pm) pm = ap[i];
      end
      pm = pm % 4;
      und = a[31:28] != REGION_MEMORY || a[27:20] > SLOT_SRAM;
      sel = (a[27:20] == SLOT_SRAM || (a[27:20] == SLOT_ZERO && rmp)) ? SEL_SRAM : SEL_FLASH;
      ea = a & ((sel == SEL_SRAM) ? 32'h7fff : 32'h3ffff);
    end
    mis = !cf && ((s == SIZE_WORD && a[1:0] != 2'h0) || (s == SIZE_HALF && a[0]));
    pr = pen && !(pm == 3 || (pm == 1 && (fl[4] || fl[0])) || (pm == 2 && (fl[4] || fl[0] || !fl[2])));
    t = cf ? TYPE_FETCH : (fl[2] ? TYPE_WRITE : TYPE_READ);
    m.issue(fl[4], fl[3], a, s, fl[2], fl[1], fl[0]);
    #1;
    chk(bus_abort, und | mis | pr);
    chk(mem_valid, !(und | mis | pr));
    if (und | mis | pr) begin
      axr(OFF_ABORT_STATUS_REG);
      chk(rd, {6'h0, !fl[4], fl[4], 6'h0, !fl[4], fl[4], 4'h0, t, s, 5'h0, pr, mis, und});
      axr(OFF_ABORT_ADDRESS_REG);
      chk(rd, a);
    end else begin
      chk(mem_sel, sel);
      chk(mem_addr, ea);
      chk(mem_by_cpu, !fl[4]);
    end
  endtask : acc
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize
  // Main sequence.
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, rmp, pen} = 8'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'hf;
    pp = 0;
    void'($urandom(32'h4094));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    axr(OFF_PROTECTION_ENABLE_REG);
    chk(rd, 32'h0);
    axr(8'h0c);
    chk(rr, RESP_SLVERR);
    axw(OFF_PROTECTION_AREA_REG, 32'hffff_ffff);
    axr(OFF_PROTECTION_AREA_REG);
    chk(rd, AREA_WRITE_MASK);
    s_axi_wstrb <= 4'h2;
    axw(OFF_PROTECTION_AREA_REG, 32'h0);
    s_axi_wstrb <= 4'hf;
    axr(OFF_PROTECTION_AREA_REG);
    chk(rd, AREA_WRITE_MASK & 32'hffff_00ff);
    axw(OFF_PROTECTION_AREA_REG, 32'h0);
    $display("test registers done");
    acc(5'b01001, 32'h0000_0003, SIZE_WORD);
    acc(5'b01011, 32'h0000_0003, SIZE_WORD);
    acc(5'b10100, 32'h0010_0001, SIZE_HALF);
    acc(5'b11000, 32'h3000_0000, SIZE_BYTE);
    chk({gd, gc}, 2'h2);
    acc(5'b01101, 32'h0030_0000, SIZE_BYTE);
    acc(5'b01001, 32'h0014_0005, SIZE_BYTE);
    acc(5'b01100, 32'h0020_8006, SIZE_HALF);
    acc(5'b01000, 32'hffff_f004, SIZE_WORD);
    acc(5'b01001, 32'h5000_0002, SIZE_WORD);
    $display("test decode done");
    for (int i = 0; i < 3; i++) begin
      axw(OFF_REMAP_CONTROL_REG, i[0] ? 32'h0 : 32'h1);
      rmp = rmp ^ !i[0];
      #1 chk(remap_active, rmp);
      acc(5'b01001, 32'h0000_0104, SIZE_WORD);
    end
    axw(OFF_REMAP_CONTROL_REG, 32'h1);
    aresetn <= 1'b0;
    @(posedge aclk);
    aresetn <= 1'b1;
    #1 chk(remap_active, 1'b0);
    $display("test remap done");
    for (int i = 0; i < 24; i++) begin
      rv = $urandom;
      acc({rv[0], 1'b1, rv[27:25]}, {10'h0, rv[2:1], rv[22:3]}, rv[24] ? SIZE_WORD : {1'b0, rv[23]});
    end
    $display("test random done");
    axw(OFF_PROTECTION_AREA_REG, 32'h0000_00d1);
    axw(OFF_PERIPHERAL_PROTECTION_REG, 32'h2);
    axw(OFF_PROTECTION_ENABLE_REG, 32'h1);
    {ap[0], al[0], pp, pen} = {32'd1, 32'h40_0000, 32'd2, 1'b1};
    acc(5'b01000, 32'h0010_0400, SIZE_WORD);
    acc(5'b01101, 32'h0010_0400, SIZE_WORD);
    acc(5'b01000, 32'hffff_f000, SIZE_WORD);
    acc(5'b01100, 32'hffff_f000, SIZE_WORD);
    acc(5'b10100, 32'h0000_0010, SIZE_WORD);
    axw(OFF_PROTECTION_AREA_REG + 8'h4, 32'h0000_00d3);
    {ap[1], al[1]} = {32'd3, 32'h40_0000};
    acc(5'b01000, 32'h0010_0400, SIZE_WORD);
    axw(OFF_PROTECTION_AREA_REG, 32'h1);
    al[0] = 1024;
    acc(5'b01000, 32'h0010_0400, SIZE_WORD);
    axw(OFF_PROTECTION_AREA_REG + 8'h4, 32'h3);
    al[1] = 1024;
    acc(5'b01001, 32'h0010_0400, SIZE_WORD);
    $display("test protection done");
    summarize();
  end
endmodule : testbench
